// >>> verilog/i2cras_defines.vh
// Constants for the two-wire register access slave: addresses, offsets, fields, reset values.
// Included by the slave module; holds definitions only.
`ifndef I2CRAS_DEFINES_VH
`define I2CRAS_DEFINES_VH

`define I2CRAS_ADDR_MAIN1 7'h48
`define I2CRAS_ADDR_MAIN0 7'h40
`define I2CRAS_ADDR_TEST 7'h49

`define I2CRAS_APB_CTRL 12'h000
`define I2CRAS_APB_STATUS 12'h004
`define I2CRAS_APB_POINTER 12'h008

`define I2CRAS_CTRL_UNLOCK_BIT 0
`define I2CRAS_UNLOCK_RESET 1'b0
`define I2CRAS_STRAP_WAIT 2'h2

`define I2CRAS_CH_BASE 8'h00
`define I2CRAS_CH_EN_MSB 2
`define I2CRAS_CH_EN_LSB 0
`define I2CRAS_CH_ADE_BIT 3
`define I2CRAS_CH_RESET 8'h08

`define I2CRAS_EN_OFF_A 3'h4
`define I2CRAS_EN_OFF_B 3'h5
`define I2CRAS_EN_ON_A 3'h6
`define I2CRAS_EN_ON_B 3'h7

`define I2CRAS_ST_IDLE 3'h0
`define I2CRAS_ST_RX 3'h1
`define I2CRAS_ST_ACK 3'h2
`define I2CRAS_ST_TX 3'h3
`define I2CRAS_ST_RACK 3'h4

`define I2CRAS_PH_ADDR 2'h0
`define I2CRAS_PH_PTR 2'h1
`define I2CRAS_PH_DATA 2'h2

`endif

// >>> verilog/i2cras_slave.v
// Two-wire register access slave with an APB control port and regulator channel outputs.
// Assumes scl_i/sda_i come from open-drain pins with external pull-ups and are asynchronous.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "i2cras_defines.vh"

module i2cras_slave #(
  parameter NCH = 3,
  parameter AW = 4,
  parameter [7:0] CH_RESET = `I2CRAS_CH_RESET
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  input wire addr_sel,
  input wire [NCH-1:0] seq_request,
  output reg [NCH-1:0] regulator_output_channel,
  output reg [NCH-1:0] discharge_on
);

  localparam NREGS = 1 << AW;

  // Decide from the enable code whether the channel runs, given the sequencer request.
  function chan_on;
    input [2:0] code;
    input req;
    begin
      if (code == `I2CRAS_EN_OFF_A || code == `I2CRAS_EN_OFF_B)
        chan_on = 1'b0;
      else if (code == `I2CRAS_EN_ON_A || code == `I2CRAS_EN_ON_B)
        chan_on = 1'b1;
      else
        chan_on = req;
    end
  endfunction

  function forced_on;
    input [2:0] code;
    begin
      forced_on = (code == `I2CRAS_EN_ON_A) || (code == `I2CRAS_EN_ON_B);
    end
  endfunction

  reg scl_m_reg, scl_s_reg, scl_d_reg;
  reg sda_m_reg, sda_s_reg, sda_d_reg;
  reg adr_m_reg, adr_s_reg;
  reg addr_opt_reg, addr_done_reg;
  reg [1:0] adr_wait_reg;
  reg unlock_reg;
  reg [2:0] state_reg;
  reg [1:0] phase_reg;
  reg [3:0] cnt_reg;
  reg [7:0] sh_reg;
  reg [7:0] ptr_reg;
  reg rw_reg;
  reg mack_reg;
  reg [7:0] regs [0:NREGS-1];
  integer i;

  // SCL high and low phases must each span at least four pclk cycles, which caps
  // the usable link rate well below the fastest bus mode.
  wire scl_rise = scl_s_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s_reg & scl_d_reg;
  wire start_det = scl_s_reg & scl_d_reg & ~sda_s_reg & sda_d_reg;
  wire stop_det = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;
  wire [6:0] main_addr = addr_opt_reg ? `I2CRAS_ADDR_MAIN1 : `I2CRAS_ADDR_MAIN0;
  wire addr_match = (sh_reg[7:1] == main_addr) ||
                    ((sh_reg[7:1] == `I2CRAS_ADDR_TEST) && unlock_reg);
  wire [7:0] ptr_inc = ptr_reg + 8'h01;
  wire apb_wr = psel & penable & pready & pwrite;
  wire apb_setup = psel & ~penable;
  wire apb_mapped = (paddr == `I2CRAS_APB_CTRL) || (paddr == `I2CRAS_APB_STATUS) ||
                    (paddr == `I2CRAS_APB_POINTER);

  // Pins pass two flip-flops; only the second stage and its delayed copy feed logic.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      adr_m_reg <= 1'b0;
      adr_s_reg <= 1'b0;
    end
    else
    begin
      scl_m_reg <= scl_i;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
      adr_m_reg <= addr_sel;
      adr_s_reg <= adr_m_reg;
    end
  end

  // The address option is a strap, caught once after reset has been released.
  // Capture waits until the synchroniser has been refilled from the pin, because
  // its reset value would otherwise be taken as the strap.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_opt_reg <= 1'b0;
      addr_done_reg <= 1'b0;
      adr_wait_reg <= 2'h0;
    end
    else if (!addr_done_reg)
    begin
      if (adr_wait_reg == `I2CRAS_STRAP_WAIT)
      begin
        addr_opt_reg <= adr_s_reg;
        addr_done_reg <= 1'b1;
      end
      else
        adr_wait_reg <= adr_wait_reg + 2'h1;
    end
  end

  // APB slave: no wait states, so pready rises in the access phase's first cycle.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      unlock_reg <= `I2CRAS_UNLOCK_RESET;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~apb_mapped;
      if (apb_setup)
      begin
        case (paddr)
          `I2CRAS_APB_CTRL: prdata <= {31'h00000000, unlock_reg};
          `I2CRAS_APB_STATUS: prdata <= {16'h0000, 5'h00, state_reg, 4'h0,
                                         addr_done_reg, addr_opt_reg, rw_reg, 1'b0};
          `I2CRAS_APB_POINTER: prdata <= {24'h000000, ptr_reg};
          default: prdata <= 32'h00000000;
        endcase
      end
      if (apb_wr && paddr == `I2CRAS_APB_CTRL)
        unlock_reg <= pwdata[`I2CRAS_CTRL_UNLOCK_BIT];
    end
  end

  // Serial engine. Bits are taken on SCL rising and SDA changes after SCL falling,
  // so data is stable while SCL is high. No timeout exists: a held clock just waits.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= `I2CRAS_ST_IDLE;
      phase_reg <= `I2CRAS_PH_ADDR;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      for (i = 0; i < NREGS; i = i + 1)
        regs[i] <= CH_RESET;
    end
    else if (stop_det)
    begin
      state_reg <= `I2CRAS_ST_IDLE;
      sda_oe <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= `I2CRAS_ST_RX;
      phase_reg <= `I2CRAS_PH_ADDR;
      cnt_reg <= 4'h0;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state_reg)
        `I2CRAS_ST_IDLE:
        begin
          sda_oe <= 1'b0;
        end
        `I2CRAS_ST_RX:
        begin
          if (scl_rise && cnt_reg != 4'h8)
          begin
            sh_reg <= {sh_reg[6:0], sda_s_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == 4'h8)
          begin
            case (phase_reg)
              `I2CRAS_PH_ADDR:
              begin
                if (addr_match)
                begin
                  rw_reg <= sh_reg[0];
                  sda_oe <= 1'b1;
                  state_reg <= `I2CRAS_ST_ACK;
                end
                else
                  state_reg <= `I2CRAS_ST_IDLE;
              end
              `I2CRAS_PH_PTR:
              begin
                ptr_reg <= sh_reg;
                sda_oe <= 1'b1;
                state_reg <= `I2CRAS_ST_ACK;
              end
              default:
              begin
                regs[ptr_reg[AW-1:0]] <= sh_reg;
                ptr_reg <= ptr_inc;
                sda_oe <= 1'b1;
                state_reg <= `I2CRAS_ST_ACK;
              end
            endcase
          end
        end
        `I2CRAS_ST_ACK:
        begin
          if (scl_fall)
          begin
            cnt_reg <= 4'h0;
            if (phase_reg == `I2CRAS_PH_ADDR && rw_reg)
            begin
              sh_reg <= regs[ptr_reg[AW-1:0]];
              sda_oe <= ~regs[ptr_reg[AW-1:0]][7];
              state_reg <= `I2CRAS_ST_TX;
            end
            else
            begin
              sda_oe <= 1'b0;
              state_reg <= `I2CRAS_ST_RX;
              phase_reg <= (phase_reg == `I2CRAS_PH_ADDR) ? `I2CRAS_PH_PTR : `I2CRAS_PH_DATA;
            end
          end
        end
        `I2CRAS_ST_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == 4'h7)
            begin
              sda_oe <= 1'b0;
              state_reg <= `I2CRAS_ST_RACK;
            end
            else
            begin
              sh_reg <= {sh_reg[6:0], 1'b0};
              sda_oe <= ~sh_reg[6];
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        `I2CRAS_ST_RACK:
        begin
          if (scl_rise)
            mack_reg <= ~sda_s_reg;
          else if (scl_fall)
          begin
            if (mack_reg)
            begin
              ptr_reg <= ptr_inc;
              sh_reg <= regs[ptr_inc[AW-1:0]];
              sda_oe <= ~regs[ptr_inc[AW-1:0]][7];
              cnt_reg <= 4'h0;
              state_reg <= `I2CRAS_ST_TX;
            end
            else
              state_reg <= `I2CRAS_ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= `I2CRAS_ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Channel outputs, one per channel register starting at register offset I2CRAS_CH_BASE, not at the pointer.
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      wire [7:0] cfg = regs[(`I2CRAS_CH_BASE + g) % NREGS];
      wire [2:0] code = cfg[`I2CRAS_CH_EN_MSB:`I2CRAS_CH_EN_LSB];
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          regulator_output_channel[g] <= 1'b0;
          discharge_on[g] <= 1'b0;
        end
        else
        begin
          regulator_output_channel[g] <= chan_on(code, seq_request[g]);
          discharge_on[g] <= cfg[`I2CRAS_CH_ADE_BIT] & ~chan_on(code, seq_request[g]) &
                             ~forced_on(code);
        end
      end
    end
  endgenerate

endmodule // i2cras_slave

`default_nettype wire

// >>> testbench/i2cras_slave_properties.sv
// Port checker for the two-wire register slave.
// Assumes it is bound to the slave and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module i2cras_slave_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [2:0] regulator_output_channel,
  input wire logic [2:0] discharge_on
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("sda_o driven high");
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  err_rdata_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad refused access");
  // The pin is seen through synchronisers, so drive changes land while SCL is low.
  oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("sda_oe rose while scl high");
  oe_hold_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("sda_oe moved while scl high");
  disch_off_a: assert property ((discharge_on & regulator_output_channel) == 3'h0)
    else $error("discharge while channel on");
  cover property ($rose(sda_oe));
  cover property (pslverr);
  cover property ($fell(discharge_on[1]));
endmodule // i2cras_slave_properties
bind i2cras_slave i2cras_slave_properties i_props (.pclk, .presetn, .psel, .penable,
  .prdata, .pready, .pslverr, .scl_i, .sda_o, .sda_oe, .regulator_output_channel,
  .discharge_on);
`default_nettype wire

// >>> testbench/i2cras_master.sv
// Behavioural two-wire bus master: makes SCL and pulls SDA low through sda_low.
// Assumes a pull-up outside resolves SDA; SCL stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module i2cras_master (
  output var logic scl,
  output var logic sda_low,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Phases of 200 ns give SCL 400 ns; the odd 13 ns keeps it off the pclk grid.
  task automatic start();
    #113 sda_low = 1'b0;
    #100 scl = 1'b1;
    #100 sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask
  task automatic stop();
    #100 sda_low = 1'b1;
    #100 scl = 1'b1;
    #100 sda_low = 1'b0;
    #100;
  endtask
  task automatic xb(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      #100 sda_low = !d[i];
      #100 scl = 1'b1;
      #100 q[i] = sda;
      #100 scl = 1'b0;
    end
  endtask
endmodule // i2cras_master
`default_nettype wire

// >>> testbench/i2cras_slave_test.sv
// Self-checking bench for the two-wire register slave: APB tasks and a bus master model.
// Assumes register bytes reset to the slave's default channel value.
`timescale 1ns/1ps
`include "i2cras_defines.vh"
`default_nettype none
module i2cras_slave_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sda_o, sda_oe, scl, m_low, err, addr_sel = 1'b1;
  logic [2:0] seq_request = 3'h0, chan, dis;
  logic [8:0] q;
  int bad_count = 0, n_tests = 0;
  wire logic sda = !(m_low | sda_oe);
  i2cras_slave i_i2cras_slave (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .addr_sel,
    .seq_request, .regulator_output_channel(chan), .discharge_on(dis));
  i2cras_master i_i2cras_master (.scl, .sda_low(m_low), .sda);
  initial forever #25 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'(pready), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tx(input logic [7:0] b, input logic ak);
    i_i2cras_master.xb({b, 1'b1}, q);
    chk("ack", 32'(q[0]), 32'(!ak));
  endtask
  task automatic rx(input logic nack, input logic [7:0] e);
    i_i2cras_master.xb({8'hFF, nack}, q);
    chk("rdata", 32'(q[8:1]), 32'(e));
  endtask
  task automatic aq(input logic [6:0] a, input logic ak);
    i_i2cras_master.start();
    tx({a, 1'b0}, ak);
    i_i2cras_master.stop();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("dis", 32'(dis), 32'h7);
    seq_request <= 3'h5;
    repeat (2) @(posedge pclk);
    chk("chan", 32'(chan), 32'h5);
    chk("dis", 32'(dis), 32'h2);
    apb(1'b0, `I2CRAS_APB_STATUS, 32'h0);
    chk("strap", rd & 32'h4, 32'h4);
    apb(1'b0, 12'h00C, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    seq_request <= 3'h7;
    i_i2cras_master.start();
    tx(8'h90, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h0C, 1'b1);
    #20000;
    tx(8'h0E, 1'b1);
    tx(8'h07, 1'b1);
    i_i2cras_master.stop();
    apb(1'b0, `I2CRAS_APB_POINTER, 32'h0);
    chk("ptr", rd & 32'hFF, 32'h3);
    chk("chan", 32'(chan), 32'h6);
    chk("dis", 32'(dis), 32'h1);
    i_i2cras_master.start();
    tx(8'h90, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h05, 1'b1);
    i_i2cras_master.start();
    tx(8'h91, 1'b1);
    rx(1'b0, 8'h0E);
    rx(1'b1, 8'h07);
    i_i2cras_master.stop();
    apb(1'b0, `I2CRAS_APB_POINTER, 32'h0);
    chk("ptr", rd & 32'hFF, 32'h2);
    chk("chan", 32'(chan), 32'h6);
    chk("dis", 32'(dis), 32'h0);
    aq(7'h49, 1'b0);
    aq(7'h40, 1'b0);
    apb(1'b1, `I2CRAS_APB_CTRL, 32'h1);
    aq(7'h49, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    addr_sel <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    aq(7'h48, 1'b0);
    aq(7'h40, 1'b1);
    aq(7'h49, 1'b0);
    chk("chan", 32'(chan), 32'h7);
    results();
  end
  initial
  begin
    #1000000;
    bad_count++;
    results();
  end
endmodule // i2cras_slave_test
`default_nettype wire
